/* File: verilog/amp_ctrl_regs.vh */
// register offsets, field positions, reset values and counts of the amp control bank
`ifndef AMP_CTRL_REGS_VH
`define AMP_CTRL_REGS_VH

`define OFS_POWER_CONTROL 4'h0
`define OFS_GAIN_EDGE 4'h1
`define OFS_CONVERTER 4'h2
`define OFS_VOLUME 4'h3
`define OFS_PORT_A 4'h4
`define OFS_PORT_B 4'h5
`define OFS_SUPPLY 4'h6
`define OFS_LIMIT_A 4'h7
`define OFS_LIMIT_B 4'h8
`define OFS_LIMIT_C 4'h9
`define OFS_FLAGS 4'ha
`define OFS_FAULT 4'hb

`define RST_POWER_CONTROL 8'h81
`define RST_GAIN_EDGE 8'h01
`define RST_CONVERTER 8'h32
`define RST_VOLUME 8'h40
`define RST_PORT_A 8'h11
`define RST_PORT_B 8'h00
`define RST_LIMIT_A 8'ha4
`define RST_LIMIT_B 8'h51
`define RST_LIMIT_C 8'h22
`define RST_FAULT 8'h18

`define BIT_AUTO_SLEEP 7
`define BIT_BATT_SENSE_OFF 6
`define BIT_SOFT_RESET 1
`define BIT_GLOBAL_SLEEP 0
`define BIT_LOW_EMI 4
`define GAIN_MSB 1
`define GAIN_LSB 0
`define WR_MASK_POWER 8'hfd

`define ZERO_RUN_LEN 2048

`endif

/* File: verilog/zero_run_detect.v */
// counter of consecutive zero audio samples with auto-sleep state
`timescale 1ns/10ps
`include "amp_ctrl_regs.vh"

module zero_run_detect #(
    parameter SAMPLE_W = 24,
    parameter RUN_LEN = `ZERO_RUN_LEN
) (
    input wire core_clk,
    input wire nrst,
    input wire clear,
    input wire enable,
    input wire sample_valid,
    input wire [SAMPLE_W-1:0] sample_data,
    output reg asleep
);
    localparam CW = 12;
    reg [CW-1:0] zero_count;

    // count zero samples, sleep after the run, wake on any nonzero one
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            zero_count <= {CW{1'b0}};
            asleep <= 1'b0;
        end
        else if (clear || !enable)
        begin
            zero_count <= {CW{1'b0}};
            asleep <= 1'b0;
        end
        else if (sample_valid)
        begin
            if (sample_data != {SAMPLE_W{1'b0}})
            begin
                zero_count <= {CW{1'b0}};
                asleep <= 1'b0;
            end
            else if (!asleep)
            begin
                if (zero_count == RUN_LEN[CW-1:0] - 1'b1)
                begin
                    zero_count <= {CW{1'b0}};
                    asleep <= 1'b1;
                end
                else
                begin
                    zero_count <= zero_count + 1'b1;
                end
            end
        end
    end
endmodule // zero_run_detect

/* File: verilog/amp_control_register_bank.v */
// control and status register bank of the mono digital-input amplifier
`timescale 1ns/10ps
`include "amp_ctrl_regs.vh"

module amp_control_register_bank #(
    parameter SAMPLE_W = 24,
    parameter RUN_LEN = `ZERO_RUN_LEN
) (
    input wire core_clk,
    input wire nrst,
    input wire reg_wr,
    input wire reg_rd,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output reg reg_rvalid,
    input wire sample_valid,
    input wire [SAMPLE_W-1:0] sample_data,
    input wire [7:0] supply_voltage,
    input wire [7:0] fault_status,
    output reg blocks_sleep,
    output reg auto_asleep,
    output reg battery_sense_on,
    output reg low_emi_edges,
    output reg [1:0] output_gain_range,
    output reg soft_reset_pulse,
    output reg [7:0] converter_ctl,
    output reg [7:0] volume_ctl,
    output reg [7:0] port_ctl_a,
    output reg [7:0] port_ctl_b,
    output reg [7:0] limit_ctl_a,
    output reg [7:0] limit_ctl_b,
    output reg [7:0] limit_ctl_c,
    output reg [7:0] fault_ctl
);
    reg [7:0] power_control;
    reg [7:0] gain_and_edge_control;
    reg [7:0] converter_control;
    reg [7:0] digital_volume;
    reg [7:0] audio_port_control_a;
    reg [7:0] audio_port_control_b;
    reg [7:0] level_limit_control_a;
    reg [7:0] level_limit_control_b;
    reg [7:0] level_limit_control_c;
    reg [7:0] fault_recovery_control;
    reg soft_reset;
    reg [7:0] next_rdata;
    wire asleep;
    wire soft_reset_req;
    wire [11:0] wr_sel;

    // soft reset request comes from a power register write with bit 1 set
    assign soft_reset_req = reg_wr && (reg_addr == `OFS_POWER_CONTROL)
        && reg_wdata[`BIT_SOFT_RESET];

    // zero-sample run detection, cleared on soft reset or while auto-sleep (power bit 7) is off
    zero_run_detect #(
        .SAMPLE_W(SAMPLE_W),
        .RUN_LEN(RUN_LEN)
    ) u_zero_run (
        .core_clk(core_clk),
        .nrst(nrst),
        .clear(soft_reset),
        .enable(power_control[`BIT_AUTO_SLEEP]),
        .sample_valid(sample_valid),
        .sample_data(sample_data),
        .asleep(asleep)
    );

    // one-hot select of an offset; unmapped offsets shift out to zero
    function [11:0] offset_select;
        input [3:0] ofs;
        begin
            offset_select = 12'h001 << ofs;
        end
    endfunction

    // write strobe decoded; read-only offsets have no storage to hit
    assign wr_sel = reg_wr ? offset_select(reg_addr) : 12'h000;

    // soft reset strobe, high for the edge after the reset write
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            soft_reset <= 1'b0;
        else
            soft_reset <= soft_reset_req;
    end

    // power register; the soft reset bit is a strobe, never stored
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            power_control <= `RST_POWER_CONTROL;
        else if (soft_reset_req)
            power_control <= `RST_POWER_CONTROL;
        else if (wr_sel[`OFS_POWER_CONTROL])
            power_control <= reg_wdata & `WR_MASK_POWER;
    end

    // gain and edge rate register
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            gain_and_edge_control <= `RST_GAIN_EDGE;
        else if (soft_reset_req)
            gain_and_edge_control <= `RST_GAIN_EDGE;
        else if (wr_sel[`OFS_GAIN_EDGE])
            gain_and_edge_control <= reg_wdata;
    end

    // converter control register
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            converter_control <= `RST_CONVERTER;
        else if (soft_reset_req)
            converter_control <= `RST_CONVERTER;
        else if (wr_sel[`OFS_CONVERTER])
            converter_control <= reg_wdata;
    end

    // digital volume register
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            digital_volume <= `RST_VOLUME;
        else if (soft_reset_req)
            digital_volume <= `RST_VOLUME;
        else if (wr_sel[`OFS_VOLUME])
            digital_volume <= reg_wdata;
    end

    // first audio port register
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            audio_port_control_a <= `RST_PORT_A;
        else if (soft_reset_req)
            audio_port_control_a <= `RST_PORT_A;
        else if (wr_sel[`OFS_PORT_A])
            audio_port_control_a <= reg_wdata;
    end

    // second audio port register
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            audio_port_control_b <= `RST_PORT_B;
        else if (soft_reset_req)
            audio_port_control_b <= `RST_PORT_B;
        else if (wr_sel[`OFS_PORT_B])
            audio_port_control_b <= reg_wdata;
    end

    // first level limit register
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            level_limit_control_a <= `RST_LIMIT_A;
        else if (soft_reset_req)
            level_limit_control_a <= `RST_LIMIT_A;
        else if (wr_sel[`OFS_LIMIT_A])
            level_limit_control_a <= reg_wdata;
    end

    // second level limit register
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            level_limit_control_b <= `RST_LIMIT_B;
        else if (soft_reset_req)
            level_limit_control_b <= `RST_LIMIT_B;
        else if (wr_sel[`OFS_LIMIT_B])
            level_limit_control_b <= reg_wdata;
    end

    // third level limit register
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            level_limit_control_c <= `RST_LIMIT_C;
        else if (soft_reset_req)
            level_limit_control_c <= `RST_LIMIT_C;
        else if (wr_sel[`OFS_LIMIT_C])
            level_limit_control_c <= reg_wdata;
    end

    // fault recovery register
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            fault_recovery_control <= `RST_FAULT;
        else if (soft_reset_req)
            fault_recovery_control <= `RST_FAULT;
        else if (wr_sel[`OFS_FAULT])
            fault_recovery_control <= reg_wdata;
    end

    // read mux; soft reset bit reads zero, status registers show inputs
    always @*
    begin
        case (reg_addr)
            `OFS_POWER_CONTROL: next_rdata = power_control;
            `OFS_GAIN_EDGE: next_rdata = gain_and_edge_control;
            `OFS_CONVERTER: next_rdata = converter_control;
            `OFS_VOLUME: next_rdata = digital_volume;
            `OFS_PORT_A: next_rdata = audio_port_control_a;
            `OFS_PORT_B: next_rdata = audio_port_control_b;
            `OFS_SUPPLY: next_rdata = supply_voltage;
            `OFS_LIMIT_A: next_rdata = level_limit_control_a;
            `OFS_LIMIT_B: next_rdata = level_limit_control_b;
            `OFS_LIMIT_C: next_rdata = level_limit_control_c;
            `OFS_FLAGS: next_rdata = fault_status;
            `OFS_FAULT: next_rdata = fault_recovery_control;
            default: next_rdata = 8'h00;
        endcase
    end

    // registered read answer, one cycle after the request
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
            begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // power state outputs toward the analog and audio blocks
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            blocks_sleep <= 1'b1;
            auto_asleep <= 1'b0;
            battery_sense_on <= 1'b0;
            soft_reset_pulse <= 1'b0;
        end
        else
        begin
            blocks_sleep <= power_control[`BIT_GLOBAL_SLEEP] | asleep;
            auto_asleep <= asleep;
            battery_sense_on <= ~power_control[`BIT_BATT_SENSE_OFF]
                & ~power_control[`BIT_GLOBAL_SLEEP];
            soft_reset_pulse <= soft_reset;
        end
    end

    // power stage edge rate and full-scale gain selection
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            low_emi_edges <= 1'b0;
            output_gain_range <= 2'h1;
        end
        else
        begin
            low_emi_edges <= gain_and_edge_control[`BIT_LOW_EMI];
            output_gain_range <=
                gain_and_edge_control[`GAIN_MSB:`GAIN_LSB];
        end
    end

    // copies of the plain control registers for the audio path
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            converter_ctl <= `RST_CONVERTER;
            volume_ctl <= `RST_VOLUME;
            port_ctl_a <= `RST_PORT_A;
            port_ctl_b <= `RST_PORT_B;
            limit_ctl_a <= `RST_LIMIT_A;
            limit_ctl_b <= `RST_LIMIT_B;
            limit_ctl_c <= `RST_LIMIT_C;
            fault_ctl <= `RST_FAULT;
        end
        else
        begin
            converter_ctl <= converter_control;
            volume_ctl <= digital_volume;
            port_ctl_a <= audio_port_control_a;
            port_ctl_b <= audio_port_control_b;
            limit_ctl_a <= level_limit_control_a;
            limit_ctl_b <= level_limit_control_b;
            limit_ctl_c <= level_limit_control_c;
            fault_ctl <= fault_recovery_control;
        end
    end
endmodule // amp_control_register_bank

/* File: bench/amp_ctrl_props.sv */
// assertion checker for the amp control register bank ports
`timescale 1ns/10ps
`include "amp_ctrl_regs.vh"
module amp_ctrl_props #(
    parameter SAMPLE_W = 24
) (
    input wire core_clk,
    input wire nrst,
    input wire reg_wr,
    input wire reg_rd,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire reg_rvalid,
    input wire sample_valid,
    input wire [SAMPLE_W-1:0] sample_data,
    input wire blocks_sleep,
    input wire auto_asleep,
    input wire battery_sense_on,
    input wire low_emi_edges,
    input wire [1:0] output_gain_range,
    input wire soft_reset_pulse
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    reg [7:0] wd1;
    reg [7:0] wd2;
    // write data of two edges back, what the outputs must show now
    always @(posedge core_clk)
    begin
        wd1 <= reg_wdata;
        wd2 <= wd1;
    end
    // power register writes, plain and soft reset
    sequence s_pwr_set;
        reg_wr && reg_addr == `OFS_POWER_CONTROL && !reg_wdata[1];
    endsequence
    sequence s_soft_wr;
        reg_wr && reg_addr == `OFS_POWER_CONTROL && reg_wdata[1];
    endsequence
    a_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    a_unmapped_zero: assert property (reg_rd && reg_addr > `OFS_FAULT
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_sleep_follows: assert property (s_pwr_set |-> ##2
        blocks_sleep == (wd2[0] | auto_asleep)) else $error("sleep wrong");
    a_sense_follows: assert property (s_pwr_set |-> ##2
        battery_sense_on == !(wd2[6] | wd2[0])) else $error("sense wrong");
    a_gain_follows: assert property (reg_wr && reg_addr == 4'h1
        |-> ##2 output_gain_range == wd2[1:0]) else $error("gain wrong");
    a_edge_follows: assert property (reg_wr && reg_addr == 4'h1
        |-> ##2 low_emi_edges == wd2[4]) else $error("edge rate wrong");
    a_soft_pulse: assert property (s_soft_wr |-> ##[1:3]
        soft_reset_pulse ##1 !soft_reset_pulse) else $error("no reset pulse");
    a_soft_restore: assert property (s_soft_wr |-> ##2 blocks_sleep
        && output_gain_range == 2'b01 && !low_emi_edges)
        else $error("soft reset left state");
    a_wake_nonzero: assert property (auto_asleep && sample_valid
        && sample_data != 0 |-> ##2 !auto_asleep) else $error("no wake");
endmodule // amp_ctrl_props

/* File: bench/sample_source.sv */
// audio sample source feeding the zero-run detector
`timescale 1ns/10ps
module sample_source #(
    parameter SAMPLE_W = 24
) (
    input wire core_clk,
    output reg sample_valid,
    output reg [SAMPLE_W-1:0] sample_data
);
    initial
    begin
        sample_valid = 1'b0;
        sample_data = {SAMPLE_W{1'b1}};
    end
    // n samples of one value; data inverted between valid cycles
    task send(input integer n, input [SAMPLE_W-1:0] v);
        integer i;
        for (i = 0; i < n; i = i + 1)
        begin
            @(posedge core_clk);
            sample_valid <= 1'b1;
            sample_data <= v;
            @(posedge core_clk);
            sample_valid <= 1'b0;
            sample_data <= ~v;
        end
    endtask
endmodule // sample_source

/* File: bench/test_amp_control_register_bank.sv */
// self-checking bench for the amp control register bank
`timescale 1ns/10ps
`include "amp_ctrl_regs.vh"
module test_amp_control_register_bank;
    localparam RUN = `ZERO_RUN_LEN;
    localparam [127:0] RV = 128'h00000000_183c2251_a45a0011_40320181;
    localparam [127:0] PAT = 128'ha5a5a5a5_a5a5a5a1_a5a580a5_a5a51241;
    localparam [127:0] EXW = 128'h00000000_a53ca5a1_a55a80a5_a5a51241;
    reg core_clk = 1'b0;
    reg nrst = 1'b0;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg [3:0] reg_addr = 4'h0;
    reg [7:0] reg_wdata = 8'h00;
    reg [7:0] supply_voltage = 8'h5a;
    reg [7:0] fault_status = 8'h3c;
    wire sample_valid, reg_rvalid, blocks_sleep, auto_asleep;
    wire battery_sense_on, low_emi_edges, soft_reset_pulse;
    wire [1:0] output_gain_range;
    wire [23:0] sample_data;
    wire [7:0] reg_rdata, converter_ctl, volume_ctl, port_ctl_a, port_ctl_b;
    wire [7:0] limit_ctl_a, limit_ctl_b, limit_ctl_c, fault_ctl;
    integer errors = 0;
    integer n_checks = 0;
    integer a;
    always #5 core_clk = ~core_clk;
    amp_control_register_bank #(.SAMPLE_W(24), .RUN_LEN(RUN)) i_dut (
        .core_clk(core_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .sample_valid(sample_valid),
        .sample_data(sample_data), .supply_voltage(supply_voltage),
        .fault_status(fault_status), .blocks_sleep(blocks_sleep),
        .auto_asleep(auto_asleep), .battery_sense_on(battery_sense_on),
        .low_emi_edges(low_emi_edges), .output_gain_range(output_gain_range),
        .soft_reset_pulse(soft_reset_pulse), .converter_ctl(converter_ctl),
        .volume_ctl(volume_ctl), .port_ctl_a(port_ctl_a),
        .port_ctl_b(port_ctl_b), .limit_ctl_a(limit_ctl_a),
        .limit_ctl_b(limit_ctl_b), .limit_ctl_c(limit_ctl_c),
        .fault_ctl(fault_ctl));
    sample_source #(.SAMPLE_W(24)) i_src (.core_clk(core_clk),
        .sample_valid(sample_valid), .sample_data(sample_data));
    // compare one value and count it
    task chk(input [63:0] nm, input [7:0] exp, input [7:0] got);
    begin
        n_checks = n_checks + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("CHECK FAILED %0s exp %h got %h", nm, exp, got);
        end
    end
    endtask
    task wr(input [3:0] ad, input [7:0] d);
    begin
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    end
    endtask
    task rd(input [3:0] ad, input [7:0] exp);
    begin
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk("rvalid", 8'h01, {7'h00, reg_rvalid});
        chk("rdata", exp, reg_rdata);
    end
    endtask
    // outputs follow one edge after the write or sample edge
    task settle;
    begin
        @(posedge core_clk);
        #1;
    end
    endtask
    task tally_and_finish;
    begin
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask
    // watchdog: the tests need about 12400 cycles
    initial
    begin
        #300000;
        errors = errors + 1;
        tally_and_finish;
    end
    initial
    begin
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        for (a = 0; a < 16; a = a + 1)
            rd(a[3:0], RV[a*8 +: 8]);
        chk("sleep", 8'h01, {7'h00, blocks_sleep});
        for (a = 0; a < 16; a = a + 1)
            wr(a[3:0], PAT[a*8 +: 8]);
        for (a = 0; a < 16; a = a + 1)
            rd(a[3:0], EXW[a*8 +: 8]);
        chk("conv", 8'ha5, converter_ctl);
        chk("limit_b", 8'ha1, limit_ctl_b);
        chk("volume", 8'ha5, volume_ctl);
        chk("port_a", 8'ha5, port_ctl_a);
        chk("port_b", 8'h80, port_ctl_b);
        chk("limit_a", 8'ha5, limit_ctl_a);
        chk("limit_c", 8'ha5, limit_ctl_c);
        chk("fault", 8'ha5, fault_ctl);
        chk("sense", 8'h00, {7'h00, battery_sense_on});
        chk("edges", 8'h01, {7'h00, low_emi_edges});
        for (a = 0; a < 4; a = a + 1)
        begin
            wr(4'h1, a[7:0]);
            settle;
            chk("gain", a[7:0], {6'h00, output_gain_range});
            chk("edges", 8'h00, {7'h00, low_emi_edges});
        end
        wr(4'h0, 8'h00);
        settle;
        chk("sleep", 8'h00, {7'h00, blocks_sleep});
        chk("sense", 8'h01, {7'h00, battery_sense_on});
        wr(4'h0, 8'h02);
        settle;
        chk("gain", 8'h01, {6'h00, output_gain_range});
        chk("sleep", 8'h01, {7'h00, blocks_sleep});
        chk("conv", 8'h32, converter_ctl);
        chk("pulse", 8'h01, {7'h00, soft_reset_pulse});
        chk("volume", 8'h40, volume_ctl);
        chk("fault", 8'h18, fault_ctl);
        rd(4'h0, 8'h81);
        chk("pulse", 8'h00, {7'h00, soft_reset_pulse});
        wr(4'h0, 8'h80);
        i_src.send(RUN - 1, 24'h0);
        i_src.send(1, 24'h000001);
        i_src.send(RUN - 1, 24'h0);
        settle;
        chk("asleep", 8'h00, {7'h00, auto_asleep});
        i_src.send(1, 24'h0);
        settle;
        chk("asleep", 8'h01, {7'h00, auto_asleep});
        chk("sleep", 8'h01, {7'h00, blocks_sleep});
        i_src.send(1, 24'h800000);
        settle;
        chk("asleep", 8'h00, {7'h00, auto_asleep});
        chk("sleep", 8'h00, {7'h00, blocks_sleep});
        wr(4'h0, 8'h00);
        i_src.send(RUN, 24'h0);
        settle;
        chk("asleep", 8'h00, {7'h00, auto_asleep});
        wr(4'h1, 8'h13);
        settle;
        chk("edges", 8'h01, {7'h00, low_emi_edges});
        @(posedge core_clk);
        nrst <= 1'b0;
        settle;
        chk("sleep", 8'h01, {7'h00, blocks_sleep});
        chk("gain", 8'h01, {6'h00, output_gain_range});
        chk("edges", 8'h00, {7'h00, low_emi_edges});
        @(posedge core_clk);
        nrst <= 1'b1;
        rd(4'h1, 8'h01);
        rd(4'h0, 8'h81);
        tally_and_finish;
    end
endmodule // test_amp_control_register_bank
bind amp_control_register_bank amp_ctrl_props #(.SAMPLE_W(SAMPLE_W)) i_props (
    .core_clk(core_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .sample_valid(sample_valid),
    .sample_data(sample_data), .blocks_sleep(blocks_sleep),
    .auto_asleep(auto_asleep), .battery_sense_on(battery_sense_on),
    .low_emi_edges(low_emi_edges), .output_gain_range(output_gain_range),
    .soft_reset_pulse(soft_reset_pulse));
